// File: rtl/timer_xy_conn.sv
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
module timer_xy_conn (
	input wire logic core_clk,
	input wire logic srst,
	input timer_xy_pkg::reg_req_t bus_req,
	input wire logic capture_input_pin,
	input wire logic [7:0] x_count_value,
	input wire logic [7:0] y_count_value,
	output logic [7:0] rdata_r,
	output timer_xy_pkg::chan_regs_t chan_regs_r,
	output timer_xy_pkg::count_load_t count_load_r,
	output logic bank_select_r,
	output logic x_clock_select_r,
	output logic y_clock_select_r,
	output logic cascade_16bit_r,
	output logic x_counts_y_match_r,
	output logic capture_arm_r,
	output logic irq_r
);
	import timer_xy_pkg::*;

	// ****************************************
	// Storage and decode
	// ****************************************
	logic [7:0] cap_conn_r;
	logic [7:0] bank_ctl_r;
	logic [7:0] xy_clock_r;
	logic [1:0] irq_status_r;
	logic [1:0] irq_enable_r;
	logic read_zero_seen_r;
	logic [7:0] rise_capture_reg;
	logic [7:0] fall_capture_reg;
	logic rise_pulse;
	logic done_pulse;
	logic bank;
	logic wr;
	logic rd;
	logic read_block;
	logic [1:0] irq_nxt;
	logic [7:0] rdata_nxt;

	function automatic logic hit(input logic [15:0] a, input logic [15:0] target);
		return a == target;
	endfunction

	function automatic logic cascade_src(input logic [7:0] control);
		return control[CLK_SRC_MSB:0] == CLK_SRC_CASCADE;
	endfunction

	assign bank = bank_ctl_r[BANK_SELECT_BIT];
	assign wr = bus_req.wr;
	assign rd = bus_req.rd;
	assign read_block = rd && !bank &&
		(hit(bus_req.addr, ADDR_RISE_OR_YA) || hit(bus_req.addr, ADDR_FALL_OR_YB));

	pulse_capture u_capture (
		.core_clk(core_clk),
		.srst(srst),
		.capture_input_pin(capture_input_pin),
		.armed(capture_arm_r),
		.read_block(read_block),
		.x_count_value(x_count_value),
		.rise_capture_reg(rise_capture_reg),
		.fall_capture_reg(fall_capture_reg),
		.rise_pulse(rise_pulse),
		.done_pulse(done_pulse)
	);

	// ****************************************
	// Connection registers
	// ****************************************

	// Reserved bits are plain storage; software is trusted to leave them zero.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			cap_conn_r <= RST_ZERO;
			bank_ctl_r <= RST_ZERO;
			xy_clock_r <= RST_ZERO;
		end else if (wr) begin
			if (hit(bus_req.addr, ADDR_CAPTURE_CONN)) begin
				cap_conn_r <= bus_req.wdata;
			end
			if (hit(bus_req.addr, ADDR_BANK_SELECT)) begin
				bank_ctl_r <= bus_req.wdata;
			end
			if (hit(bus_req.addr, ADDR_XY_CLOCK)) begin
				xy_clock_r <= bus_req.wdata;
			end
		end
	end

	// Arming needs a prior read that saw the arm bit at zero; any write to the capture connection register consumes that permission.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			read_zero_seen_r <= 1'b0;
		end else if (wr && hit(bus_req.addr, ADDR_CAPTURE_CONN)) begin
			read_zero_seen_r <= 1'b0;
		end else if (rd && hit(bus_req.addr, ADDR_CAPTURE_CONN)) begin
			read_zero_seen_r <= !capture_arm_r;
		end
	end

	// Disarm on completion; a write of zero also disarms, a write of one without the read is dropped.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			capture_arm_r <= 1'b0;
		end else if (wr && hit(bus_req.addr, ADDR_CAPTURE_CONN)) begin
			if (bus_req.wdata[CAPTURE_ARM_BIT]) begin
				capture_arm_r <= (read_zero_seen_r | capture_arm_r) & !done_pulse;
			end else begin
				capture_arm_r <= 1'b0;
			end
		end else if (done_pulse) begin
			capture_arm_r <= 1'b0;
		end
	end

	// Bank bit and clock selects leave as flops for the timer channels.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			bank_select_r <= 1'b0;
			x_clock_select_r <= 1'b0;
			y_clock_select_r <= 1'b0;
			cascade_16bit_r <= 1'b0;
			x_counts_y_match_r <= 1'b0;
		end else begin
			bank_select_r <= bank;
			x_clock_select_r <= xy_clock_r[X_CLOCK_SELECT_BIT];
			y_clock_select_r <= xy_clock_r[Y_CLOCK_SELECT_BIT];
			cascade_16bit_r <= xy_clock_r[Y_CLOCK_SELECT_BIT] &
				cascade_src(chan_regs_r.y_control);
			x_counts_y_match_r <= xy_clock_r[X_CLOCK_SELECT_BIT] &
				cascade_src(chan_regs_r.x_control);
		end
	end

	// ****************************************
	// Shared window writes
	// ****************************************

	// Capture registers are read-only; Y has nothing behind the constant C slot.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			chan_regs_r <= '{RST_ZERO, RST_ZERO, RST_CONSTANT, RST_CONSTANT, RST_CONSTANT,
				RST_ZERO, RST_ZERO, RST_CONSTANT, RST_CONSTANT};
		end else if (wr) begin
			case (bus_req.addr)
				ADDR_CONTROL: begin
					if (bank) chan_regs_r.y_control <= bus_req.wdata;
					else chan_regs_r.x_control <= bus_req.wdata;
				end
				ADDR_STATUS: begin
					if (bank) chan_regs_r.y_status <= bus_req.wdata;
					else chan_regs_r.x_status <= bus_req.wdata;
				end
				ADDR_RISE_OR_YA: begin
					if (bank) chan_regs_r.y_constant_a <= bus_req.wdata;
				end
				ADDR_FALL_OR_YB: begin
					if (bank) chan_regs_r.y_constant_b <= bus_req.wdata;
				end
				ADDR_X_CONST_C: begin
					if (!bank) chan_regs_r.x_constant_c <= bus_req.wdata;
				end
				ADDR_X_CONST_A: begin
					chan_regs_r.x_constant_a <= bus_req.wdata;
				end
				ADDR_X_CONST_B: begin
					chan_regs_r.x_constant_b <= bus_req.wdata;
				end
				default: begin
				end
			endcase
		end
	end

	// Counter writes are passed on as a one-cycle load to the channel that owns the count.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			count_load_r <= '{1'b0, 1'b0, RST_ZERO};
		end else begin
			count_load_r.x_load <= wr && hit(bus_req.addr, ADDR_COUNTER) && !bank;
			count_load_r.y_load <= wr && hit(bus_req.addr, ADDR_COUNTER) && bank;
			count_load_r.data <= bus_req.wdata;
		end
	end

	// ****************************************
	// Interrupt status
	// ****************************************

	// A new event in the clear cycle survives because the set term is ORed last.
	always_comb begin
		irq_nxt = irq_status_r;
		if (wr && hit(bus_req.addr, ADDR_IRQ_CLEAR)) begin
			irq_nxt = irq_nxt & ~bus_req.wdata[1:0];
		end
		irq_nxt[IRQ_RISE_BIT] = irq_nxt[IRQ_RISE_BIT] | rise_pulse;
		irq_nxt[IRQ_DONE_BIT] = irq_nxt[IRQ_DONE_BIT] | done_pulse;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			irq_status_r <= RST_IRQ;
			irq_enable_r <= RST_IRQ;
			irq_r <= 1'b0;
		end else begin
			irq_status_r <= irq_nxt;
			if (wr && hit(bus_req.addr, ADDR_IRQ_ENABLE)) begin
				irq_enable_r <= bus_req.wdata[1:0];
			end
			irq_r <= |(irq_nxt & irq_enable_r);
		end
	end

	// ****************************************
	// Read path
	// ****************************************

	// Unmapped addresses and empty Y slots return zero.
	always_comb begin
		rdata_nxt = RST_ZERO;
		case (bus_req.addr)
			ADDR_CONTROL: rdata_nxt = bank ? chan_regs_r.y_control : chan_regs_r.x_control;
			ADDR_STATUS: rdata_nxt = bank ? chan_regs_r.y_status : chan_regs_r.x_status;
			ADDR_RISE_OR_YA: rdata_nxt = bank ? chan_regs_r.y_constant_a : rise_capture_reg;
			ADDR_FALL_OR_YB: rdata_nxt = bank ? chan_regs_r.y_constant_b : fall_capture_reg;
			ADDR_COUNTER: rdata_nxt = bank ? y_count_value : x_count_value;
			ADDR_X_CONST_C: rdata_nxt = bank ? RST_ZERO : chan_regs_r.x_constant_c;
			ADDR_X_CONST_A: rdata_nxt = chan_regs_r.x_constant_a;
			ADDR_X_CONST_B: rdata_nxt = chan_regs_r.x_constant_b;
			ADDR_CAPTURE_CONN: begin
				rdata_nxt = cap_conn_r;
				rdata_nxt[CAPTURE_ARM_BIT] = capture_arm_r;
			end
			ADDR_BANK_SELECT: rdata_nxt = bank_ctl_r;
			ADDR_XY_CLOCK: rdata_nxt = xy_clock_r;
			ADDR_IRQ_STATUS: rdata_nxt = {6'h00, irq_status_r};
			ADDR_IRQ_ENABLE: rdata_nxt = {6'h00, irq_enable_r};
			default: rdata_nxt = RST_ZERO;
		endcase
	end

	// Read data stand only in the cycle after the strobe.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			rdata_r <= RST_ZERO;
		end else begin
			rdata_r <= rd ? rdata_nxt : RST_ZERO;
		end
	end

endmodule // timer_xy_conn

// File: rtl/timer_xy_pkg.sv
package timer_xy_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [15:0] ADDR_CONTROL = 16'hFFF0;
	localparam logic [15:0] ADDR_STATUS = 16'hFFF1;
	localparam logic [15:0] ADDR_RISE_OR_YA = 16'hFFF2;
	localparam logic [15:0] ADDR_FALL_OR_YB = 16'hFFF3;
	localparam logic [15:0] ADDR_COUNTER = 16'hFFF4;
	localparam logic [15:0] ADDR_X_CONST_C = 16'hFFF5;
	localparam logic [15:0] ADDR_X_CONST_A = 16'hFFF6;
	localparam logic [15:0] ADDR_X_CONST_B = 16'hFFF7;
	localparam logic [15:0] ADDR_CAPTURE_CONN = 16'hFFE0;
	localparam logic [15:0] ADDR_BANK_SELECT = 16'hFFE1;
	localparam logic [15:0] ADDR_XY_CLOCK = 16'hFFE2;
	localparam logic [15:0] ADDR_IRQ_STATUS = 16'hFFE3;
	localparam logic [15:0] ADDR_IRQ_CLEAR = 16'hFFE4;
	localparam logic [15:0] ADDR_IRQ_ENABLE = 16'hFFE5;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CAPTURE_ARM_BIT = 4;
	localparam int BANK_SELECT_BIT = 7;
	localparam int X_CLOCK_SELECT_BIT = 5;
	localparam int Y_CLOCK_SELECT_BIT = 4;
	localparam int CLK_SRC_MSB = 2;
	localparam logic [2:0] CLK_SRC_CASCADE = 3'h4;
	localparam int IRQ_RISE_BIT = 0;
	localparam int IRQ_DONE_BIT = 1;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_CONSTANT = 8'hFF;
	localparam logic [1:0] RST_IRQ = 2'h0;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic x_load;
		logic y_load;
		logic [7:0] data;
	} count_load_t;

	typedef struct packed {
		logic [7:0] x_control;
		logic [7:0] x_status;
		logic [7:0] x_constant_a;
		logic [7:0] x_constant_b;
		logic [7:0] x_constant_c;
		logic [7:0] y_control;
		logic [7:0] y_status;
		logic [7:0] y_constant_a;
		logic [7:0] y_constant_b;
	} chan_regs_t;

endpackage

// File: rtl/pulse_capture.sv
`timescale 1ns/1ps
module pulse_capture (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic capture_input_pin,
	input wire logic armed,
	input wire logic read_block,
	input wire logic [7:0] x_count_value,
	output logic [7:0] rise_capture_reg,
	output logic [7:0] fall_capture_reg,
	output logic rise_pulse,
	output logic done_pulse
);
	import timer_xy_pkg::*;

	typedef enum logic [1:0] {WAIT_RISE, WAIT_FALL, PAIR_DONE} cap_state_t;

	cap_state_t state_r;
	logic sync1_r;
	logic sync2_r;
	logic prev_r;
	logic pend_rise_r;
	logic pend_fall_r;
	logic rise_ev;
	logic fall_ev;
	logic take_rise;
	logic take_fall;

	// Two flops on the pin, then edge compare on the stable copies only.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			prev_r <= 1'b0;
		end else begin
			sync1_r <= capture_input_pin;
			sync2_r <= sync1_r;
			prev_r <= sync2_r;
		end
	end

	assign rise_ev = sync2_r & ~prev_r;
	assign fall_ev = ~sync2_r & prev_r;

	// An edge that meets a capture read is held until a cycle with no capture read, so the read sees a stable byte.
	assign take_rise = armed && state_r == WAIT_RISE && (rise_ev | pend_rise_r) && !read_block;
	assign take_fall = armed && state_r == WAIT_FALL && (fall_ev | pend_fall_r) && !read_block;

	// Pending edges remember only one event; a second edge during a read stall is lost.
	always_ff @(posedge core_clk) begin
		if (srst || !armed) begin
			pend_rise_r <= 1'b0;
			pend_fall_r <= 1'b0;
		end else begin
			pend_rise_r <= state_r == WAIT_RISE && (rise_ev | pend_rise_r) && read_block;
			pend_fall_r <= state_r == WAIT_FALL && (fall_ev | pend_fall_r) && read_block;
		end
	end

	// Sequence: the disarmed state forces the rise wait, so a lone fall does nothing.
	always_ff @(posedge core_clk) begin
		if (srst || !armed) begin
			state_r <= WAIT_RISE;
		end else begin
			case (state_r)
				WAIT_RISE: begin
					if (take_rise) begin
						state_r <= WAIT_FALL;
					end
				end
				WAIT_FALL: begin
					if (take_fall) begin
						state_r <= PAIR_DONE;
					end
				end
				// The arm bit drops one cycle after the fall capture; holding here stops a
				// fresh rise in that gap from overwriting the finished measurement.
				PAIR_DONE: begin
					state_r <= PAIR_DONE;
				end
				default: begin
					state_r <= WAIT_RISE;
				end
			endcase
		end
	end

	// Capture registers load the X count at the taken edge.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			rise_capture_reg <= RST_ZERO;
			fall_capture_reg <= RST_ZERO;
			rise_pulse <= 1'b0;
			done_pulse <= 1'b0;
		end else begin
			if (take_rise) begin
				rise_capture_reg <= x_count_value;
			end
			if (take_fall) begin
				fall_capture_reg <= x_count_value;
			end
			rise_pulse <= take_rise;
			done_pulse <= take_fall;
		end
	end

endmodule // pulse_capture

// File: verif/timer_xy_conn_asserts.sv
`timescale 1ns/1ps
// ********
// Checker
// ********
module timer_xy_conn_asserts
	import timer_xy_pkg::*;
(
	input wire logic core_clk,
	input wire logic srst,
	input timer_xy_pkg::reg_req_t bus_req,
	input wire logic capture_input_pin,
	input wire logic [7:0] x_count_value,
	input wire logic [7:0] y_count_value,
	input wire logic [7:0] rdata_r,
	input timer_xy_pkg::chan_regs_t chan_regs_r,
	input timer_xy_pkg::count_load_t count_load_r,
	input wire logic bank_select_r,
	input wire logic x_clock_select_r,
	input wire logic y_clock_select_r,
	input wire logic cascade_16bit_r,
	input wire logic x_counts_y_match_r,
	input wire logic capture_arm_r,
	input wire logic irq_r
);
	logic cw, bw, xw;
	// Decoded writes; a bank write needs two cycles to reach the output copy.
	assign cw = bus_req.wr && bus_req.addr == ADDR_CAPTURE_CONN;
	assign bw = bus_req.wr && bus_req.addr == ADDR_BANK_SELECT;
	assign xw = bus_req.wr && bus_req.addr == ADDR_XY_CLOCK;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	property p_rd_idle;
		!$past(bus_req.rd) |-> rdata_r == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	property p_arm_set;
		$rose(capture_arm_r) |-> $past(cw && bus_req.wdata[4]) || $past(cw && bus_req.wdata[4], 2);
	endproperty
	a_arm_set: assert property (p_arm_set) else $error("arm set without write");
	property p_arm_clr;
		$fell(capture_arm_r) |-> $past(cw) || $past(cw, 2) || !$past(capture_input_pin, 3);
	endproperty
	a_arm_clr: assert property (p_arm_clr) else $error("arm cleared early");
	property p_bank;
		bw |-> ##2 bank_select_r == $past(bus_req.wdata[BANK_SELECT_BIT], 2);
	endproperty
	a_bank: assert property (p_bank) else $error("bank select wrong");
	property p_clk_sel;
		xw |-> ##2 x_clock_select_r == $past(bus_req.wdata[5], 2) &&
			y_clock_select_r == $past(bus_req.wdata[4], 2);
	endproperty
	a_clk_sel: assert property (p_clk_sel) else $error("clock select wrong");
	property p_cascade;
		(y_clock_select_r && chan_regs_r.y_control[2:0] == CLK_SRC_CASCADE) [*3] |-> cascade_16bit_r;
	endproperty
	a_cascade: assert property (p_cascade) else $error("cascade missing");
	// The X side follows its select bit and the X source field of the cycle before.
	property p_xmatch;
		x_counts_y_match_r == (x_clock_select_r &&
			$past(chan_regs_r.x_control[2:0]) == CLK_SRC_CASCADE);
	endproperty
	a_xmatch: assert property (p_xmatch) else $error("match count select wrong");
	property p_load;
		bus_req.wr && bus_req.addr == ADDR_COUNTER && !$past(bw) |=> count_load_r.y_load ==
			$past(bank_select_r) && count_load_r.x_load == !$past(bank_select_r) &&
			count_load_r.data == $past(bus_req.wdata);
	endproperty
	a_load: assert property (p_load) else $error("counter load wrong");
	property p_cnt_rd;
		bus_req.rd && bus_req.addr == ADDR_COUNTER && !$past(bw) |=> rdata_r ==
			($past(bank_select_r) ? $past(y_count_value) : $past(x_count_value));
	endproperty
	a_cnt_rd: assert property (p_cnt_rd) else $error("counter read wrong");
	c_armed: cover property (cw ##1 capture_arm_r);
	c_done: cover property ($fell(capture_arm_r));
	c_casc: cover property (cascade_16bit_r);
endmodule // timer_xy_conn_asserts
bind timer_xy_conn timer_xy_conn_asserts u_asserts (.core_clk(core_clk), .srst(srst),
	.bus_req(bus_req), .capture_input_pin(capture_input_pin), .x_count_value(x_count_value),
	.y_count_value(y_count_value), .rdata_r(rdata_r), .chan_regs_r(chan_regs_r),
	.count_load_r(count_load_r), .bank_select_r(bank_select_r),
	.x_clock_select_r(x_clock_select_r), .y_clock_select_r(y_clock_select_r),
	.cascade_16bit_r(cascade_16bit_r), .x_counts_y_match_r(x_counts_y_match_r),
	.capture_arm_r(capture_arm_r), .irq_r(irq_r));

// File: verif/pulse_source.sv
`timescale 1ns/1ps
// ********
// Pulse source
// ********
module pulse_source (
	input wire logic core_clk,
	input wire logic go,
	input wire logic [7:0] len,
	output logic capture_input_pin
);
	int n = 0;
	initial capture_input_pin = 1'b0;
	// One pulse per request, len cycles high, so narrow and wide pulses both occur.
	always @(posedge core_clk) begin
		if (go && n == 0) begin
			capture_input_pin <= 1'b1;
			n <= len;
		end else if (n > 0) begin
			n <= n - 1;
			capture_input_pin <= n > 1;
		end
	end
endmodule // pulse_source

// File: verif/timer_xy_conn_bench.sv
`timescale 1ns/1ps
// ********
// Bench
// ********
module timer_xy_conn_bench;
	import timer_xy_pkg::*;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic go = 1'b0;
	logic pin, casc, arm_r, irq_r, xmatch;
	logic [7:0] len = 8'h14;
	logic [7:0] xcnt = 8'h00;
	logic [7:0] ycnt = 8'h00;
	logic [7:0] rdata_r, a, b, d;
	logic [7:0] m [10];
	logic [15:0] regs [6] = '{ADDR_CONTROL, ADDR_STATUS, ADDR_X_CONST_C, ADDR_X_CONST_A,
		ADDR_X_CONST_B, ADDR_XY_CLOCK};
	reg_req_t bus_req = '0;
	int miscompares = 0;
	int num_checks = 0;
	int i;
	always #2 core_clk = ~core_clk;
	timer_xy_conn u_dut (.core_clk(core_clk), .srst(srst), .bus_req(bus_req),
		.capture_input_pin(pin), .x_count_value(xcnt), .y_count_value(ycnt), .rdata_r(rdata_r),
		.chan_regs_r(), .count_load_r(), .bank_select_r(), .x_clock_select_r(),
		.y_clock_select_r(), .cascade_16bit_r(casc), .x_counts_y_match_r(xmatch),
		.capture_arm_r(arm_r), .irq_r(irq_r));
	pulse_source u_src (.core_clk(core_clk), .go(go), .len(len), .capture_input_pin(pin));
	// Constants come up all ones, everything else zero.
	function automatic logic [7:0] reset_val(input logic [15:0] ad);
		return (ad inside {ADDR_X_CONST_A, ADDR_X_CONST_B, ADDR_X_CONST_C}) ? RST_CONSTANT : RST_ZERO;
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] ad, input logic [7:0] v);
		@(posedge core_clk);
		bus_req.addr <= ad;
		bus_req.wdata <= v;
		bus_req.wr <= 1'b1;
		@(posedge core_clk);
		bus_req.wr <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe, so it is taken there.
	task automatic rd(input logic [15:0] ad);
		@(posedge core_clk);
		bus_req.addr <= ad;
		bus_req.rd <= 1'b1;
		@(posedge core_clk);
		bus_req.rd <= 1'b0;
		#1 d = rdata_r;
	endtask
	task automatic rdc(input logic [15:0] ad, input logic [7:0] exp);
		rd(ad);
		chk(d, exp);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic arm();
		rdc(ADDR_CAPTURE_CONN, 8'h00);
		wr(ADDR_CAPTURE_CONN, 8'h10);
	endtask
	// Capture registers are read while the pulse runs; the fall edge meets a read, to hit the delayed capture.
	task automatic pulse(input logic [7:0] ra, input logic [7:0] fa);
		@(posedge core_clk);
		xcnt <= ra;
		len <= 8'h14;
		go <= 1'b1;
		@(posedge core_clk);
		go <= 1'b0;
		repeat (6) rd(ADDR_RISE_OR_YA);
		@(posedge core_clk);
		xcnt <= fa;
		repeat (12) rd(ADDR_FALL_OR_YB);
	endtask
	task automatic wait_disarm();
		for (i = 0; i < 40 && arm_r !== 1'b0; i++)
			@(posedge core_clk);
		if (i == 40) begin
			$display("BAD %0t arm stuck", $time);
			miscompares++;
			conclude();
		end
	endtask
	initial begin
		d = $urandom(32'hBFA9193F);
		repeat (20) @(posedge core_clk);
		srst <= 1'b0;
		foreach (regs[k]) rdc(regs[k], reset_val(regs[k]));
		$display("reset test done");
		foreach (regs[k]) m[k] = 8'($urandom) & ((regs[k] == ADDR_XY_CLOCK) ? 8'h30 : 8'hFF);
		foreach (regs[k]) wr(regs[k], m[k]);
		foreach (regs[k]) rdc(regs[k], m[k]);
		wr(ADDR_RISE_OR_YA, 8'h5A);
		rdc(ADDR_RISE_OR_YA, 8'h00);
		wr(16'hFFEF, 8'hFF);
		rdc(16'hFFEF, 8'h00);
		$display("register test done");
		wr(ADDR_BANK_SELECT, 8'h80);
		for (i = 6; i < 10; i++) m[i] = 8'($urandom);
		for (i = 6; i < 10; i++) wr(ADDR_CONTROL + 16'(i - 6), m[i]);
		for (i = 6; i < 10; i++) rdc(ADDR_CONTROL + 16'(i - 6), m[i]);
		wr(ADDR_X_CONST_C, 8'h77);
		rdc(ADDR_X_CONST_C, 8'h00);
		rdc(ADDR_X_CONST_A, m[3]);
		wr(ADDR_COUNTER, m[8]);
		@(posedge core_clk);
		ycnt <= m[9];
		rdc(ADDR_COUNTER, m[9]);
		wr(ADDR_CONTROL, {5'h00, CLK_SRC_CASCADE});
		wr(ADDR_XY_CLOCK, 8'h10);
		repeat (3) @(posedge core_clk);
		#1 chk({7'h00, casc}, 8'h01);
		wr(ADDR_BANK_SELECT, 8'h00);
		rdc(ADDR_X_CONST_C, m[2]);
		wr(ADDR_CONTROL, {5'h00, CLK_SRC_CASCADE});
		wr(ADDR_XY_CLOCK, 8'h20);
		repeat (2) @(posedge core_clk);
		#1 chk({7'h00, xmatch}, 8'h01);
		$display("bank test done");
		pulse(8'h11, 8'h22);
		rdc(ADDR_RISE_OR_YA, 8'h00);
		wr(ADDR_CAPTURE_CONN, 8'h10);
		rdc(ADDR_CAPTURE_CONN, 8'h00);
		wr(ADDR_IRQ_ENABLE, 8'h03);
		a = 8'($urandom);
		b = 8'($urandom);
		arm();
		pulse(a, b);
		wait_disarm();
		rdc(ADDR_RISE_OR_YA, a);
		rdc(ADDR_FALL_OR_YB, b);
		chk({7'h00, irq_r}, 8'h01);
		rdc(ADDR_IRQ_STATUS, 8'h03);
		wr(ADDR_IRQ_CLEAR, 8'h03);
		rdc(ADDR_IRQ_STATUS, 8'h00);
		chk({7'h00, irq_r}, 8'h00);
		wr(ADDR_IRQ_ENABLE, 8'h00);
		@(posedge core_clk);
		len <= 8'h3C;
		go <= 1'b1;
		@(posedge core_clk);
		go <= 1'b0;
		repeat (10) @(posedge core_clk);
		arm();
		repeat (70) @(posedge core_clk);
		rdc(ADDR_CAPTURE_CONN, 8'h10);
		pulse(b, a);
		wait_disarm();
		rdc(ADDR_FALL_OR_YB, a);
		chk({7'h00, irq_r}, 8'h00);
		wr(ADDR_IRQ_ENABLE, 8'h01);
		rdc(ADDR_IRQ_STATUS, 8'h03);
		chk({7'h00, irq_r}, 8'h01);
		arm();
		rdc(ADDR_CAPTURE_CONN, 8'h10);
		wr(ADDR_CAPTURE_CONN, 8'h00);
		rdc(ADDR_CAPTURE_CONN, 8'h00);
		$display("capture test done");
		conclude();
	end
endmodule // timer_xy_conn_bench
